/* hw/dtb_engine.sv */
// Digital receive steering, tone generation and burst timing behind an APB slave
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "dtb_defs.svh"

// Notes on behaviour
// - Too-short tone bursts leave receive data untouched
// - Valid-duration tone pair latches its code
// - After valid pause, code held until next
// - Short dropout changes nothing, signal stays registered
// - Delayed steering low after guard, whole signal
// - Status b2 sets on new data, read clears
// - Enabled interrupt on new data, cleared by read
// - Transmit uses same 4-bit code as receiver
// - Transmit write latches code, makes 2-of-8
// - Tone period is 32 equal segments
// - Divider counts to code value, resets, restarts
// - Divider output steps sine table address counter
// - Eight standard frequencies, two independent generators
// - All tone and burst timing from reference
// - Tone starts at once when enabled, in burst mode on transmit write
// - Burst mode: 51 ms tone, 51 ms pause
// - Burst and pause done sets transmitter ready
// - Call-progress mode doubles burst and pause
// - Call-progress burst mode transmits, never receives
// - Single-tone mode makes one group only
// - Registration latches code, steering held active
// - Call-progress mode blocks detection, passes tones out only with interrupt enabled
module dtb_engine
  import dtb_pkg::*;
#(
  parameter int BURST_TICKS = int'(`DTB_BURST_TICKS),
  parameter int GTP_CYCLES  = int'(`DTB_GTP_CYCLES),
  parameter int GTA_CYCLES  = int'(`DTB_GTA_CYCLES)
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        refClockIn,
  input  wire logic        earlyToneDetect,
  input  wire dtb_code_t   detectedCode,
  input  wire logic        cpSquareIn,
  output logic             steerInGuardOut,
  output logic             delayedSteerN,
  output dtb_code_t        rxCodeBits,
  output logic             irqOrProgressOut,
  output logic             irqOrProgressOe,
  output logic      [7:0]  lowSample,
  output logic      [7:0]  highSample
);

  if (BURST_TICKS < 2 || BURST_TICKS > 8000000)
    $error("BURST_TICKS out of range");
  if (GTP_CYCLES < 1 || GTP_CYCLES > 1048575 || GTA_CYCLES < 1 || GTA_CYCLES > 1048575)
    $error("Guard cycles out of range");

  // Standard digit code to row (low) and column (high) one-hot selects
  function automatic logic [7:0] twoOfEightFor(input dtb_code_t code);
    logic [3:0] row;
    logic [3:0] col;
    row = 4'h0;
    col = 4'h0;
    unique case (code)
      4'h1, 4'h2, 4'h3, 4'hD: row = 4'h1;
      4'h4, 4'h5, 4'h6, 4'hE: row = 4'h2;
      4'h7, 4'h8, 4'h9, 4'hF: row = 4'h4;
      4'hA, 4'hB, 4'hC, 4'h0: row = 4'h8;
    endcase
    unique case (code)
      4'h1, 4'h4, 4'h7, 4'hB: col = 4'h1;
      4'h2, 4'h5, 4'h8, 4'hA: col = 4'h2;
      4'h3, 4'h6, 4'h9, 4'hC: col = 4'h4;
      4'hD, 4'hE, 4'hF, 4'h0: col = 4'h8;
    endcase
    return {col, row};
  endfunction

  function automatic logic [7:0] segLength(input logic high, input logic [3:0] sel);
    logic [7:0] len;
    len = high ? `DTB_DIV_H3 : `DTB_DIV_L3;
    if (sel[0])
      len = high ? `DTB_DIV_H0 : `DTB_DIV_L0;
    else if (sel[1])
      len = high ? `DTB_DIV_H1 : `DTB_DIV_L1;
    else if (sel[2])
      len = high ? `DTB_DIV_H2 : `DTB_DIV_L2;
    return len;
  endfunction

  // Quarter wave table, folded out to 32 points per period
  function automatic logic [7:0] sineCode(input logic [4:0] addr);
    logic [3:0] q;
    logic [7:0] v;
    q = addr[3] ? 4'(5'd16 - {1'b0, addr[3:0]}) : {1'b0, addr[2:0]};
    unique case (q)
      4'h0: v = 8'h80;
      4'h1: v = 8'h99;
      4'h2: v = 8'hB1;
      4'h3: v = 8'hC7;
      4'h4: v = 8'hDA;
      4'h5: v = 8'hEA;
      4'h6: v = 8'hF5;
      4'h7: v = 8'hFD;
      default: v = 8'hFF;
    endcase
    return addr[4] ? 8'(9'h100 - {1'b0, v}) : v;
  endfunction

  // Register group
  logic [5:0]  ctrl;
  dtb_code_t   txCode;
  logic [7:0]  twoOfEight;
  logic [19:0] guardPresent;
  logic [19:0] guardAbsent;
  logic        rxNew;
  logic        txReady;
  logic        irqPending;
  logic [5:0]  next_ctrl;
  dtb_code_t   next_txCode;
  logic [7:0]  next_twoOfEight;
  logic [19:0] next_guardPresent;
  logic [19:0] next_guardAbsent;
  logic        next_rxNew;
  logic        next_txReady;
  logic        next_irqPending;

  logic wrAccess;
  logic rdAccess;
  logic txWrite;
  logic statusRead;
  logic mapped;
  logic rxEvent;
  logic txDone;
  logic toneEnable;
  logic cpMode;
  logic irqEnable;
  logic burstEnable;

  assign wrAccess    = psel && penable && pwrite;
  assign rdAccess    = psel && penable && !pwrite;
  assign txWrite     = wrAccess && paddr == `DTB_OFF_TXDATA;
  assign statusRead  = rdAccess && paddr == `DTB_OFF_STATUS;
  assign toneEnable  = ctrl[`DTB_CTRL_TONE];
  assign cpMode      = ctrl[`DTB_CTRL_CP];
  assign irqEnable   = ctrl[`DTB_CTRL_IRQ];
  assign burstEnable = ctrl[`DTB_CTRL_BURST];
  assign mapped      = paddr inside {`DTB_OFF_TXDATA, `DTB_OFF_RXDATA, `DTB_OFF_CTRL,
                                     `DTB_OFF_STATUS, `DTB_OFF_GTP, `DTB_OFF_GTA};
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;

  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `DTB_OFF_TXDATA: prdata[3:0] = txCode;
      `DTB_OFF_RXDATA: prdata[3:0] = rxCodeBits;
      `DTB_OFF_CTRL:   prdata[5:0] = ctrl;
      `DTB_OFF_STATUS: prdata[3:0] = {!delayedSteerN, rxNew, txReady, irqPending};
      `DTB_OFF_GTP:    prdata[19:0] = guardPresent;
      `DTB_OFF_GTA:    prdata[19:0] = guardAbsent;
      default:         prdata = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_ctrl         = ctrl;
    next_txCode       = txCode;
    next_twoOfEight   = twoOfEight;
    next_guardPresent = guardPresent;
    next_guardAbsent  = guardAbsent;
    if (txWrite)
    begin
      next_txCode     = pwdata[3:0];
      next_twoOfEight = twoOfEightFor(pwdata[3:0]);
    end
    if (wrAccess && paddr == `DTB_OFF_CTRL)
      next_ctrl = pwdata[5:0];
    // Zero would disable validation, so the guards never fall below one cycle
    if (wrAccess && paddr == `DTB_OFF_GTP)
      next_guardPresent = (pwdata[19:0] == 20'h0_0000) ? 20'h0_0001 : pwdata[19:0];
    if (wrAccess && paddr == `DTB_OFF_GTA)
      next_guardAbsent = (pwdata[19:0] == 20'h0_0000) ? 20'h0_0001 : pwdata[19:0];
    // A set in the cycle of a clearing read wins
    next_rxNew      = rxEvent || (rxNew && !statusRead);
    next_txReady    = txDone || (txReady && !txWrite);
    next_irqPending = (irqEnable && !cpMode && (rxEvent || (txDone && burstEnable)))
                      || (irqPending && !statusRead);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl         <= `DTB_CTRL_RESET;
      txCode       <= 4'h0;
      twoOfEight   <= 8'h88;
      guardPresent <= 20'(GTP_CYCLES);
      guardAbsent  <= 20'(GTA_CYCLES);
      rxNew        <= 1'b0;
      txReady      <= 1'b1;
      irqPending   <= 1'b0;
    end
    else
    begin
      ctrl         <= next_ctrl;
      txCode       <= next_txCode;
      twoOfEight   <= next_twoOfEight;
      guardPresent <= next_guardPresent;
      guardAbsent  <= next_guardAbsent;
      rxNew        <= next_rxNew;
      txReady      <= next_txReady;
      irqPending   <= next_irqPending;
    end
  end

  // Open drain pin: progress square wave in call-progress mode with interrupt enabled, else interrupt
  assign irqOrProgressOut = 1'b0;
  assign irqOrProgressOe  = (cpMode && irqEnable) ? !cpSquareIn : irqPending;

  // Receive steering group
  dtb_rx_state_e rxState;
  dtb_rx_state_e next_rxState;
  logic [19:0]   guardCount;
  logic [19:0]   next_guardCount;
  dtb_code_t     next_rxCodeBits;

  always_comb
  begin
    next_rxState    = rxState;
    next_guardCount = guardCount;
    next_rxCodeBits = rxCodeBits;
    rxEvent         = 1'b0;
    if (cpMode)
    begin
      next_rxState    = RX_IDLE;
      next_guardCount = 20'h0_0000;
    end
    else
    begin
      unique case (rxState)
        RX_IDLE:
          if (earlyToneDetect)
          begin
            next_rxState    = RX_ACQUIRE;
            next_guardCount = 20'h0_0000;
          end
        RX_ACQUIRE:
          if (!earlyToneDetect)
            next_rxState = RX_IDLE;
          else if (guardCount + 20'h0_0001 >= guardPresent)
          begin
            next_rxState    = RX_VALID;
            next_rxCodeBits = detectedCode;
            rxEvent         = 1'b1;
          end
          else
            next_guardCount = guardCount + 20'h0_0001;
        RX_VALID:
          if (!earlyToneDetect)
          begin
            next_rxState    = RX_DROPOUT;
            next_guardCount = 20'h0_0000;
          end
        RX_DROPOUT:
          if (earlyToneDetect)
            next_rxState = RX_VALID;
          else if (guardCount + 20'h0_0001 >= guardAbsent)
            next_rxState = RX_IDLE;
          else
            next_guardCount = guardCount + 20'h0_0001;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState    <= RX_IDLE;
      guardCount <= 20'h0_0000;
      rxCodeBits <= 4'h0;
    end
    else
    begin
      rxState    <= next_rxState;
      guardCount <= next_guardCount;
      rxCodeBits <= next_rxCodeBits;
    end
  end

  assign steerInGuardOut = (rxState == RX_VALID);
  assign delayedSteerN   = !(rxState == RX_VALID || rxState == RX_DROPOUT);

  // Burst timing group, counted in reference ticks
  logic          refPrev;
  logic          refTick;
  dtb_burst_state_e burstState;
  dtb_burst_state_e next_burstState;
  logic [23:0]   burstCount;
  logic [23:0]   next_burstCount;
  logic [23:0]   burstLen;

  assign refTick  = refClockIn && !refPrev;
  assign burstLen = cpMode ? 24'(2 * BURST_TICKS) : 24'(BURST_TICKS);

  always_comb
  begin
    next_burstState = burstState;
    next_burstCount = burstCount;
    txDone          = 1'b0;
    if (txWrite && burstEnable)
    begin
      next_burstState = BS_TONE;
      next_burstCount = 24'h00_0000;
    end
    else if (burstState != BS_IDLE && refTick)
    begin
      if (burstCount + 24'h00_0001 >= burstLen)
      begin
        next_burstCount = 24'h00_0000;
        next_burstState = (burstState == BS_TONE) ? BS_PAUSE : BS_IDLE;
        txDone          = (burstState == BS_PAUSE);
      end
      else
        next_burstCount = burstCount + 24'h00_0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refPrev    <= 1'b0;
      burstState <= BS_IDLE;
      burstCount <= 24'h00_0000;
    end
    else
    begin
      refPrev    <= refClockIn;
      burstState <= next_burstState;
      burstCount <= next_burstCount;
    end
  end

  // Tone generator group: index 0 is the row tone, 1 the column tone
  logic       toneOn;
  logic [1:0] groupOn;
  logic [7:0] segCount [2];
  logic [4:0] phase [2];
  logic [7:0] sample [2];
  logic [7:0] next_segCount [2];
  logic [4:0] next_phase [2];
  logic [7:0] next_sample [2];
  logic [7:0] segLen [2];

  // The reference runs freely, so an enabled tone counts from the very next tick and steps after one segment
  assign toneOn = toneEnable && (!burstEnable || burstState == BS_TONE);

  always_comb
  begin
    for (int g = 0; g < 2; g++)
    begin
      groupOn[g] = toneOn && (!ctrl[`DTB_CTRL_SINGLE] || ctrl[`DTB_CTRL_SHIGH] == g[0]);
      segLen[g]  = segLength(g[0], g[0] ? twoOfEight[7:4] : twoOfEight[3:0]);
      next_segCount[g] = segCount[g];
      next_phase[g]    = phase[g];
      if (!groupOn[g])
      begin
        next_segCount[g] = 8'h00;
        next_phase[g]    = 5'h00;
      end
      else if (refTick)
      begin
        if (segCount[g] + 8'h01 >= segLen[g])
        begin
          next_segCount[g] = 8'h00;
          next_phase[g]    = phase[g] + 5'h01;
        end
        else
          next_segCount[g] = segCount[g] + 8'h01;
      end
      next_sample[g] = groupOn[g] ? sineCode(phase[g]) : `DTB_SINE_MID;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int g = 0; g < 2; g++)
      begin
        segCount[g] <= 8'h00;
        phase[g]    <= 5'h00;
        sample[g]   <= `DTB_SINE_MID;
      end
    end
    else
    begin
      for (int g = 0; g < 2; g++)
      begin
        segCount[g] <= next_segCount[g];
        phase[g]    <= next_phase[g];
        sample[g]   <= next_sample[g];
      end
    end
  end

  assign lowSample  = sample[0];
  assign highSample = sample[1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_rx_short_kept: assert property (
    rxState == RX_ACQUIRE && !earlyToneDetect |=> $stable(rxCodeBits) && rxState == RX_IDLE)
    else $error("Short burst altered receive state");
  a_rx_latch_code: assert property (
    rxEvent |=> rxCodeBits == $past(detectedCode) && rxNew && !delayedSteerN)
    else $error("Valid tone not latched");
  a_rx_pause_hold: assert property (
    rxState == RX_IDLE && !earlyToneDetect |=> $stable(rxCodeBits))
    else $error("Code changed during pause");
  a_dropout_keep: assert property (
    rxState == RX_DROPOUT && earlyToneDetect && !cpMode
    |=> rxState == RX_VALID && !delayedSteerN && $stable(rxCodeBits))
    else $error("Dropout ended the signal");
  a_steer_guard: assert property (
    $fell(delayedSteerN) |-> $past(rxState) == RX_ACQUIRE && $past(earlyToneDetect))
    else $error("Steering without guard time");
  a_status_clear: assert property (
    statusRead && !rxEvent ##1 !rxEvent |-> ##0 !rxNew)
    else $error("Status read did not clear new data");
  a_irq_on_data: assert property (
    rxEvent && irqEnable && !cpMode && !wrAccess |=> irqOrProgressOe)
    else $error("Interrupt not raised");
  a_tx_two_of_8: assert property (
    txWrite |=> txCode == $past(pwdata[3:0]) && $countones(twoOfEight) == 2)
    else $error("Transmit code not latched");
  a_phase_step: assert property (
    groupOn[0] && refTick && segCount[0] + 8'h01 >= segLen[0]
    |=> phase[0] == $past(phase[0]) + 5'h01)
    else $error("Divider did not step the table");
  a_burst_to_pause: assert property (
    burstState == BS_TONE && refTick && burstCount + 24'h00_0001 >= burstLen && !txWrite
    |=> burstState == BS_PAUSE)
    else $error("Burst length wrong");
  a_ready_after: assert property (
    txDone |=> txReady)
    else $error("Transmitter ready not set");
  a_cp_no_rx: assert property (
    cpMode |=> !rxEvent && rxState == RX_IDLE)
    else $error("Receive active in call-progress mode");

  c_rx_register:  cover property (rxEvent);
  c_rx_dropout:   cover property (rxState == RX_DROPOUT ##1 rxState == RX_VALID);
  c_burst_done:   cover property (txDone);
  c_single_tone:  cover property (ctrl[`DTB_CTRL_SINGLE] && groupOn[1] && !groupOn[0]);

endmodule

/* hw/dtb_defs.svh */
// Offsets, field positions, reset values and timing counts of the tone burst engine
`ifndef DTB_DEFS_SVH
`define DTB_DEFS_SVH

`define DTB_OFF_TXDATA 8'h00
`define DTB_OFF_RXDATA 8'h04
`define DTB_OFF_CTRL   8'h08
`define DTB_OFF_STATUS 8'h0C
`define DTB_OFF_GTP    8'h10
`define DTB_OFF_GTA    8'h14

`define DTB_CTRL_TONE   0
`define DTB_CTRL_CP     1
`define DTB_CTRL_IRQ    2
`define DTB_CTRL_BURST  3
`define DTB_CTRL_SINGLE 4
`define DTB_CTRL_SHIGH  5
`define DTB_CTRL_RESET  6'h00

`define DTB_ST_IRQ    0
`define DTB_ST_TXRDY  1
`define DTB_ST_RXNEW  2
`define DTB_ST_STEER  3

`define DTB_REF_HZ      3579545
`define DTB_CORE_HZ     25000000
`define DTB_BURST_MS    51
`define DTB_BURST_TICKS (64'(`DTB_BURST_MS) * `DTB_REF_HZ / 1000)
`define DTB_GTP_US      20000
`define DTB_GTA_US      20000
`define DTB_GTP_CYCLES  ((64'(`DTB_GTP_US) * `DTB_CORE_HZ + 999999) / 1000000)
`define DTB_GTA_CYCLES  ((64'(`DTB_GTA_US) * `DTB_CORE_HZ + 999999) / 1000000)

// Segment lengths in reference ticks: f = ref / (32 * length)
`define DTB_DIV_L0 8'hA0
`define DTB_DIV_L1 8'h92
`define DTB_DIV_L2 8'h84
`define DTB_DIV_L3 8'h76
`define DTB_DIV_H0 8'h5C
`define DTB_DIV_H1 8'h54
`define DTB_DIV_H2 8'h4C
`define DTB_DIV_H3 8'h44
`define DTB_SINE_MID 8'h80

`endif

/* hw/dtb_pkg.sv */
// Types shared by the tone burst engine
package dtb_pkg;
  typedef logic [3:0] dtb_code_t;
  typedef enum logic [1:0] {RX_IDLE, RX_ACQUIRE, RX_VALID, RX_DROPOUT} dtb_rx_state_e;
  typedef enum logic [1:0] {BS_IDLE, BS_TONE, BS_PAUSE} dtb_burst_state_e;
endpackage

/* testbench/dtb_tone_source.sv */
// Front-end stand-in: reference oscillator, tone detector and call-progress comparator
`timescale 1ns/10ps
module dtb_tone_source
  import dtb_pkg::*;
#(
  parameter int REF_CYCLES = 7
)(
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      toneOn,
  input  wire dtb_code_t toneCode,
  output logic           refClockIn,
  output logic           earlyToneDetect,
  output dtb_code_t      detectedCode,
  output logic           cpSquareIn
);
  logic [2:0] cpDiv;
  int         refCnt;

  // Free-running reference made from the core clock: an edge of its own could
  // race a core edge, and a fixed ratio keeps the expected timing exact

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      earlyToneDetect <= 1'h0;
      detectedCode    <= 4'h0;
      cpDiv           <= 3'h0;
      cpSquareIn      <= 1'h0;
      refCnt          <= 0;
      refClockIn      <= 1'h0;
    end
    else
    begin
      earlyToneDetect <= toneOn;
      // Code means nothing without a tone, so it keeps changing then
      detectedCode    <= toneOn ? toneCode : ~detectedCode;
      cpDiv           <= cpDiv + 3'h1;
      refCnt          <= (refCnt == REF_CYCLES - 1) ? 0 : refCnt + 1;
      refClockIn      <= (refCnt < REF_CYCLES / 2);
      if (cpDiv == 3'h4)
        cpSquareIn <= ~cpSquareIn;
    end
  end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the tone burst engine
`timescale 1ns/10ps
`include "dtb_defs.svh"
module tb
  import dtb_pkg::*;
;
  localparam logic [31:0] TONE   = 32'h1 << `DTB_CTRL_TONE;
  localparam logic [31:0] CP     = 32'h1 << `DTB_CTRL_CP;
  localparam logic [31:0] IRQ    = 32'h1 << `DTB_CTRL_IRQ;
  localparam logic [31:0] BURST  = 32'h1 << `DTB_CTRL_BURST;
  localparam logic [31:0] SINGLE = 32'h1 << `DTB_CTRL_SINGLE;
  localparam logic [31:0] SHIGH  = 32'h1 << `DTB_CTRL_SHIGH;
  localparam logic [31:0] S_IRQ  = 32'h1 << `DTB_ST_IRQ;
  localparam logic [31:0] S_RDY  = 32'h1 << `DTB_ST_TXRDY;
  localparam logic [31:0] S_NEW  = 32'h1 << `DTB_ST_RXNEW;
  localparam logic [31:0] S_STR  = 32'h1 << `DTB_ST_STEER;
  localparam int          REF_CYC = 7;

  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, toneOn = 1'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, refClockIn, earlyToneDetect, cpSquareIn;
  logic        steerInGuardOut, delayedSteerN, irqOrProgressOut, irqOrProgressOe;
  dtb_code_t   toneCode = 4'h0, detectedCode, rxCodeBits, codeA, codeB;
  logic [7:0]  lowSample, highSample;
  logic [33:0] expQ[$];
  logic [33:0] note;
  int          error_cnt = 0, check_count = 0, seed = 32'h4a00, n;

  always #20 core_clk = ~core_clk;

  dtb_engine #(.BURST_TICKS(8), .GTP_CYCLES(4), .GTA_CYCLES(4)) i_dtb_engine (
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refClockIn(refClockIn), .earlyToneDetect(earlyToneDetect), .detectedCode(detectedCode),
    .cpSquareIn(cpSquareIn), .steerInGuardOut(steerInGuardOut), .delayedSteerN(delayedSteerN),
    .rxCodeBits(rxCodeBits), .irqOrProgressOut(irqOrProgressOut),
    .irqOrProgressOe(irqOrProgressOe), .lowSample(lowSample), .highSample(highSample));

  dtb_tone_source #(.REF_CYCLES(REF_CYC)) i_dtb_tone_source (
    .core_clk(core_clk), .rst_n(rst_n), .toneOn(toneOn), .toneCode(toneCode),
    .refClockIn(refClockIn), .earlyToneDetect(earlyToneDetect),
    .detectedCode(detectedCode), .cpSquareIn(cpSquareIn));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // First step of a group started from phase zero: len ticks, up to one tick of
  // reference phase, then the phase and sample registers
  function automatic logic [31:0] inSeg(input int cnt, input int len);
    return 32'(cnt > REF_CYC * (len - 1) + 2 && cnt <= REF_CYC * len + 2);
  endfunction

  task automatic gaveUp();
    error_cnt++;
    $display("MISMATCH wait expected done seen timeout");
    summarize();
  endtask

  // Reads leave a note: bit 33 skips the compare, bit 32 is the expected error
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [33:0] e);
    int k;
    if (!w)
      expQ.push_back(e);
    @(posedge core_clk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'h1;
    penable <= 1'h0;
    @(posedge core_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 20);
    if (k >= 20)
      gaveUp();
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'h1, d, 34'h0_0000_0000);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'h0, 32'h0, {2'h0, exp});
  endtask

  always @(posedge core_clk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      if (expQ.size() == 0)
        check("read note", 32'h0, 32'h1);
      else
      begin
        note = expQ.pop_front();
        if (!note[33])
        begin
          check("prdata", prdata, note[31:0]);
          check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
        end
      end
    end
  end

  task automatic validTone(input dtb_code_t c);
    toneCode <= c;
    toneOn   <= 1'h1;
    repeat (9) @(posedge core_clk);
    check("steerN", 32'(delayedSteerN), 32'h0);
    check("guardOut", 32'(steerInGuardOut), 32'h1);
    check("irqOe", 32'(irqOrProgressOe), 32'h1);
    check("irqOut", 32'(irqOrProgressOut), 32'h0);
    check("rxCode", 32'(rxCodeBits), 32'(c));
    rdx(`DTB_OFF_STATUS, S_IRQ | S_RDY | S_NEW | S_STR);
    rdx(`DTB_OFF_RXDATA, 32'(c));
    check("irqOe", 32'(irqOrProgressOe), 32'h0);
    rdx(`DTB_OFF_STATUS, S_RDY | S_STR);
    // Dropout shorter than the absent guard
    toneOn <= 1'h0;
    repeat (2) @(posedge core_clk);
    toneOn <= 1'h1;
    repeat (4) @(posedge core_clk);
    check("steerN", 32'(delayedSteerN), 32'h0);
    rdx(`DTB_OFF_STATUS, S_RDY | S_STR);
    toneOn <= 1'h0;
    repeat (10) @(posedge core_clk);
    check("steerN", 32'(delayedSteerN), 32'h1);
    rdx(`DTB_OFF_RXDATA, 32'(c));
    rdx(`DTB_OFF_STATUS, S_RDY);
  endtask

  // Polls in steps of three cycles; the bounds cover one tick of phase slip
  task automatic waitReady(input int lo, input int hi);
    int k;
    k = 0;
    do
    begin
      apb(`DTB_OFF_STATUS, 1'h0, 32'h0, 34'h2_0000_0000);
      k += 3;
    end
    while (rd[`DTB_ST_TXRDY] !== 1'h1 && k < hi);
    check("ready time", 32'(k >= lo && k < hi), 32'h1);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    gaveUp();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    rdx(`DTB_OFF_STATUS, S_RDY);
    rdx(`DTB_OFF_CTRL, 32'h0);
    rdx(`DTB_OFF_GTP, 32'h4);
    apb(8'h20, 1'h0, 32'h0, 34'h1_0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rdx(`DTB_OFF_GTA, 32'h4);
    $display("test registers done");
    wr(`DTB_OFF_CTRL, IRQ);
    codeA = 4'($random(seed));
    codeB = codeA ^ 4'h5;
    validTone(codeA);
    validTone(codeB);
    toneCode <= codeA;
    toneOn   <= 1'h1;
    repeat (3) @(posedge core_clk);
    toneOn <= 1'h0;
    repeat (10) @(posedge core_clk);
    rdx(`DTB_OFF_RXDATA, 32'(codeB));
    rdx(`DTB_OFF_STATUS, S_RDY);
    $display("test receive done");
    wr(`DTB_OFF_CTRL, CP | IRQ);
    toneOn <= 1'h1;
    repeat (12) @(posedge core_clk);
    check("steerN", 32'(delayedSteerN), 32'h1);
    check("cpOut", 32'(irqOrProgressOe), 32'(!cpSquareIn));
    rdx(`DTB_OFF_RXDATA, 32'(codeB));
    check("cpOut", 32'(irqOrProgressOe), 32'(!cpSquareIn));
    toneOn <= 1'h0;
    wr(`DTB_OFF_CTRL, 32'h0);
    $display("test call progress done");
    for (n = 0; n < 16; n++)
    begin
      wr(`DTB_OFF_TXDATA, 32'(n));
      rdx(`DTB_OFF_TXDATA, 32'(n));
    end
    $display("test digit codes done");
    // Last code written is F: 852 Hz row, 1633 Hz column; waits outlast a column segment
    wr(`DTB_OFF_CTRL, TONE | SINGLE);
    repeat (600) @(posedge core_clk);
    check("highSample", 32'(highSample), 32'h80);
    wr(`DTB_OFF_CTRL, TONE | SINGLE | SHIGH);
    n = 0;
    while (highSample === 8'h80 && n < 1300)
    begin
      @(posedge core_clk);
      n++;
    end
    check("high segment", inSeg(n, `DTB_DIV_H3), 32'h1);
    repeat (600) @(posedge core_clk);
    check("lowSample", 32'(lowSample), 32'h80);
    wr(`DTB_OFF_CTRL, TONE);
    n = 0;
    while (lowSample === 8'h80 && n < 1300)
    begin
      @(posedge core_clk);
      n++;
    end
    check("tone start", inSeg(n, `DTB_DIV_L2), 32'h1);
    $display("test tone generation done");
    wr(`DTB_OFF_CTRL, TONE | BURST);
    wr(`DTB_OFF_TXDATA, 32'(codeA));
    repeat (60) @(posedge core_clk);
    rdx(`DTB_OFF_STATUS, 32'h0);
    waitReady(42, 55);
    wr(`DTB_OFF_CTRL, TONE | BURST | CP);
    wr(`DTB_OFF_TXDATA, 32'(codeB));
    repeat (150) @(posedge core_clk);
    rdx(`DTB_OFF_STATUS, 32'h0);
    waitReady(63, 76);
    $display("test burst done");
    summarize();
  end
endmodule
